// File: src/pmx_pkg.sv
// Package: opcodes, widths and operand carriers for the packed min/max/mul/SAD datapath
package pmx_pkg;

  localparam int VEC_W   = 128;
  localparam int HALF_W  = 64;
  localparam int OP_W    = 5;

  // Bias that maps signed words onto the unsigned range
  localparam logic [15:0] WORD_BIAS    = 16'h8000;
  localparam logic [15:0] WORD_ALLONES = 16'hFFFF;
  localparam logic [7:0]  BYTE_BIAS    = 8'h80;

  // Result latency in clocks after acceptance
  localparam int RESULT_LATENCY = 1;

  typedef enum logic [OP_W-1:0] {
    max_signed_word_op          = 5'h00,
    min_signed_word_op          = 5'h01,
    max_unsigned_byte_op        = 5'h02,
    min_unsigned_byte_op        = 5'h03,
    max_signed_byte_op          = 5'h04,
    min_signed_byte_op          = 5'h05,
    max_unsigned_word_op        = 5'h06,
    min_unsigned_word_op        = 5'h07,
    max_signed_dword_op         = 5'h08,
    min_signed_dword_op         = 5'h09,
    max_unsigned_dword_op       = 5'h0A,
    min_unsigned_dword_op       = 5'h0B,
    mul_high_unsigned_word_op   = 5'h0C,
    mul_high_signed_word_op     = 5'h0D,
    mul_low_word_op             = 5'h0E,
    mul_unsigned_dword_wide_op  = 5'h0F,
    mul_low_signed_dword_op     = 5'h10,
    mul_signed_dword_wide_op    = 5'h11,
    sum_abs_diff_byte_op        = 5'h12,
    add_wrap_word_op            = 5'h13,
    add_sat_unsigned_word_op    = 5'h14,
    sub_sat_unsigned_word_op    = 5'h15,
    add_sat_signed_word_op      = 5'h16,
    sub_sat_signed_word_op      = 5'h17,
    add_wrap_byte_op            = 5'h18,
    add_sat_unsigned_byte_op    = 5'h19,
    sub_sat_unsigned_byte_op    = 5'h1A,
    add_sat_signed_byte_op      = 5'h1B,
    sub_sat_signed_byte_op      = 5'h1C
  } pmx_op_t;

  // One issued request
  typedef struct packed {
    pmx_op_t          op;
    logic             wide;    // 1: 128-bit form, 0: 64-bit form
    logic             src_mem; // Second operand came from memory
    logic [VEC_W-1:0] dst;     // vector_operand_reg value
    logic [VEC_W-1:0] src;     // Register or memory value
  } pmx_req_t;

  // One result
  typedef struct packed {
    logic             valid;
    logic             illegal;
    logic [VEC_W-1:0] data;
  } pmx_rsp_t;

endpackage

// File: src/pmx_sad_half.sv
// Sum of absolute byte differences over one 64-bit half
`timescale 1ns/100ps
`default_nettype none
module pmx_sad_half
  import pmx_pkg::*;
(
  input  wire logic [HALF_W-1:0] a,
  input  wire logic [HALF_W-1:0] b,
  output logic      [HALF_W-1:0] y
);

  logic [15:0] sum;

  // Eight byte pairs reduce into the low word, upper words zero
  always_comb begin
    logic [7:0] x;
    logic [7:0] z;
    x   = 8'h00;
    z   = 8'h00;
    sum = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      x = a[i*8 +: 8];
      z = b[i*8 +: 8];
      sum = sum + {8'h00, ((x > z) ? (x - z) : (z - x))};
    end
    y = {48'h0, sum};
  end

endmodule
`default_nettype wire

// File: src/pmx_mul_dword.sv
// Signed or unsigned 32x32 multiply giving the full 64-bit product
`timescale 1ns/100ps
`default_nettype none
module pmx_mul_dword (
  input  wire logic        is_signed,
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic      [63:0] p
);

  logic [32:0] ax;
  logic [32:0] bx;
  logic [65:0] full;

  // Sign or zero extend one bit, then one signed product covers both kinds
  always_comb begin
    ax   = {is_signed & a[31], a};
    bx   = {is_signed & b[31], b};
    full = $signed(ax) * $signed(bx);
    p    = full[63:0];
  end

endmodule
`default_nettype wire

// File: src/pmx_datapath.sv
// Packed integer min/max, multiply, saturating add/sub and SAD datapath
//
// Behaviour
// - max of four signed words
// - min of four signed words
// - max of eight unsigned bytes
// - min of eight unsigned bytes
// - second operand from register or memory
// - word/byte min/max also on 128 bits
// - 128-bit adds signed byte, unsigned word, dwords
// - word multiply keeps high sixteen bits
// - word multiply keeps low sixteen bits
// - unsigned low dword multiply, full product
// - unsigned dword multiply in 64 and 128 forms
// - signed dword multiply keeps low half
// - signed widening multiply of low dwords
// - absolute difference of unsigned bytes
// - eight differences summed into low word
// - 128-bit SAD gives two word results
// - clip by min high then max low
// - unsigned clip by saturating add, subtract, add
// - signed clip biases words by 0x8000 first
// - short signed clip needs range at least 0x8000
// - saturation only for bytes and words
`timescale 1ns/100ps
`default_nettype none
module pmx_datapath
  import pmx_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     sys_rst,
  input  wire logic     req_valid,
  input  wire pmx_req_t req,
  output pmx_rsp_t      rsp
);

  pmx_rsp_t rsp_d;
  pmx_rsp_t rsp_q;

  logic [VEC_W-1:0] a;
  logic [VEC_W-1:0] b;
  logic [VEC_W-1:0] res;
  logic             illegal;
  logic [63:0]      prod [4];
  logic [63:0]      sad  [2];
  logic             mul_signed;
  logic [31:0]      mul_a [4];
  logic [31:0]      mul_b [4];

  // Narrow form uses only the low 64 bits; memory and register sources look alike
  always_comb begin
    a = req.wide ? req.dst : {64'h0, req.dst[63:0]};
    b = req.wide ? req.src : {64'h0, req.src[63:0]};
  end

  // Dword multipliers: lane-wise for low-half, even dwords for widening forms
  always_comb begin
    mul_signed = (req.op != mul_unsigned_dword_wide_op);
    for (int i = 0; i < 4; i++) begin
      if (req.op == mul_low_signed_dword_op) begin
        mul_a[i] = a[i*32 +: 32];
        mul_b[i] = b[i*32 +: 32];
      end else begin
        mul_a[i] = a[(i/2)*64 +: 32];
        mul_b[i] = b[(i/2)*64 +: 32];
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_mul
    pmx_mul_dword u_mul (
      .is_signed (mul_signed),
      .a         (mul_a[g]),
      .b         (mul_b[g]),
      .p         (prod[g])
    );
  end

  // One SAD reducer per 64-bit half
  for (genvar h = 0; h < 2; h++) begin : g_sad
    pmx_sad_half u_sad (
      .a (a[h*64 +: 64]),
      .b (b[h*64 +: 64]),
      .y (sad[h])
    );
  end

  // Lane-wise result select; no carry crosses a lane boundary
  always_comb begin
    logic signed [16:0] ws;
    logic signed [8:0]  bs;
    logic        [16:0] wu;
    logic        [8:0]  bu;
    logic signed [31:0] wp;
    res     = '0;
    illegal = 1'b0;
    ws = '0;
    bs = '0;
    wu = '0;
    bu = '0;
    wp = '0;
    unique case (req.op)
      max_signed_word_op, min_signed_word_op, max_unsigned_word_op, min_unsigned_word_op: begin
        for (int i = 0; i < 8; i++) begin
          if (req.op == max_signed_word_op)
            res[i*16 +: 16] = ($signed(a[i*16 +: 16]) > $signed(b[i*16 +: 16]))
                              ? a[i*16 +: 16] : b[i*16 +: 16];
          else if (req.op == min_signed_word_op)
            res[i*16 +: 16] = ($signed(a[i*16 +: 16]) < $signed(b[i*16 +: 16]))
                              ? a[i*16 +: 16] : b[i*16 +: 16];
          else if (req.op == max_unsigned_word_op)
            res[i*16 +: 16] = (a[i*16 +: 16] > b[i*16 +: 16]) ? a[i*16 +: 16] : b[i*16 +: 16];
          else
            res[i*16 +: 16] = (a[i*16 +: 16] < b[i*16 +: 16]) ? a[i*16 +: 16] : b[i*16 +: 16];
        end
        illegal = !req.wide && (req.op inside {max_unsigned_word_op, min_unsigned_word_op});
      end
      max_unsigned_byte_op, min_unsigned_byte_op, max_signed_byte_op, min_signed_byte_op: begin
        for (int i = 0; i < 16; i++) begin
          if (req.op == max_unsigned_byte_op)
            res[i*8 +: 8] = (a[i*8 +: 8] > b[i*8 +: 8]) ? a[i*8 +: 8] : b[i*8 +: 8];
          else if (req.op == min_unsigned_byte_op)
            res[i*8 +: 8] = (a[i*8 +: 8] < b[i*8 +: 8]) ? a[i*8 +: 8] : b[i*8 +: 8];
          else if (req.op == max_signed_byte_op)
            res[i*8 +: 8] = ($signed(a[i*8 +: 8]) > $signed(b[i*8 +: 8]))
                            ? a[i*8 +: 8] : b[i*8 +: 8];
          else
            res[i*8 +: 8] = ($signed(a[i*8 +: 8]) < $signed(b[i*8 +: 8]))
                            ? a[i*8 +: 8] : b[i*8 +: 8];
        end
        illegal = !req.wide && (req.op inside {max_signed_byte_op, min_signed_byte_op});
      end
      max_signed_dword_op, min_signed_dword_op, max_unsigned_dword_op, min_unsigned_dword_op: begin
        for (int i = 0; i < 4; i++) begin
          if (req.op == max_signed_dword_op)
            res[i*32 +: 32] = ($signed(a[i*32 +: 32]) > $signed(b[i*32 +: 32]))
                              ? a[i*32 +: 32] : b[i*32 +: 32];
          else if (req.op == min_signed_dword_op)
            res[i*32 +: 32] = ($signed(a[i*32 +: 32]) < $signed(b[i*32 +: 32]))
                              ? a[i*32 +: 32] : b[i*32 +: 32];
          else if (req.op == max_unsigned_dword_op)
            res[i*32 +: 32] = (a[i*32 +: 32] > b[i*32 +: 32]) ? a[i*32 +: 32] : b[i*32 +: 32];
          else
            res[i*32 +: 32] = (a[i*32 +: 32] < b[i*32 +: 32]) ? a[i*32 +: 32] : b[i*32 +: 32];
        end
        illegal = !req.wide;
      end
      mul_high_unsigned_word_op, mul_high_signed_word_op, mul_low_word_op: begin
        for (int i = 0; i < 8; i++) begin
          if (req.op == mul_high_signed_word_op) begin
            wp = $signed(a[i*16 +: 16]) * $signed(b[i*16 +: 16]);
            res[i*16 +: 16] = wp[31:16];
          end else begin
            wp = $signed({16'h0, a[i*16 +: 16]} * {16'h0, b[i*16 +: 16]});
            res[i*16 +: 16] = (req.op == mul_low_word_op) ? wp[15:0] : wp[31:16];
          end
        end
      end
      mul_unsigned_dword_wide_op, mul_signed_dword_wide_op: begin
        res = {prod[2], prod[0]};
        if (!req.wide)
          res[127:64] = 64'h0;
        illegal = !req.wide && (req.op == mul_signed_dword_wide_op);
      end
      mul_low_signed_dword_op: begin
        for (int i = 0; i < 4; i++)
          res[i*32 +: 32] = prod[i][31:0];
        illegal = !req.wide;
      end
      sum_abs_diff_byte_op: begin
        res = {sad[1], sad[0]};
        if (!req.wide)
          res[127:64] = 64'h0;
      end
      add_wrap_word_op, add_sat_unsigned_word_op, sub_sat_unsigned_word_op,
      add_sat_signed_word_op, sub_sat_signed_word_op: begin
        // Word saturation is what the clip sequences are built on
        for (int i = 0; i < 8; i++) begin
          wu = (req.op == sub_sat_unsigned_word_op) ? ({1'b0, a[i*16 +: 16]} - {1'b0, b[i*16 +: 16]})
                                                    : ({1'b0, a[i*16 +: 16]} + {1'b0, b[i*16 +: 16]});
          ws = (req.op == sub_sat_signed_word_op)
               ? ($signed({a[i*16+15], a[i*16 +: 16]}) - $signed({b[i*16+15], b[i*16 +: 16]}))
               : ($signed({a[i*16+15], a[i*16 +: 16]}) + $signed({b[i*16+15], b[i*16 +: 16]}));
          unique case (req.op)
            add_wrap_word_op:         res[i*16 +: 16] = wu[15:0];
            add_sat_unsigned_word_op: res[i*16 +: 16] = wu[16] ? WORD_ALLONES : wu[15:0];
            sub_sat_unsigned_word_op: res[i*16 +: 16] = wu[16] ? 16'h0000 : wu[15:0];
            default: res[i*16 +: 16] = (ws[16] != ws[15]) ? (ws[16] ? WORD_BIAS : ~WORD_BIAS)
                                                          : ws[15:0];
          endcase
        end
      end
      add_wrap_byte_op, add_sat_unsigned_byte_op, sub_sat_unsigned_byte_op,
      add_sat_signed_byte_op, sub_sat_signed_byte_op: begin
        // Only bytes and words get saturating forms; dwords have none
        for (int i = 0; i < 16; i++) begin
          bu = (req.op == sub_sat_unsigned_byte_op) ? ({1'b0, a[i*8 +: 8]} - {1'b0, b[i*8 +: 8]})
                                                    : ({1'b0, a[i*8 +: 8]} + {1'b0, b[i*8 +: 8]});
          bs = (req.op == sub_sat_signed_byte_op)
               ? ($signed({a[i*8+7], a[i*8 +: 8]}) - $signed({b[i*8+7], b[i*8 +: 8]}))
               : ($signed({a[i*8+7], a[i*8 +: 8]}) + $signed({b[i*8+7], b[i*8 +: 8]}));
          unique case (req.op)
            add_wrap_byte_op:         res[i*8 +: 8] = bu[7:0];
            add_sat_unsigned_byte_op: res[i*8 +: 8] = bu[8] ? 8'hFF : bu[7:0];
            sub_sat_unsigned_byte_op: res[i*8 +: 8] = bu[8] ? 8'h00 : bu[7:0];
            default: res[i*8 +: 8] = (bs[8] != bs[7]) ? (bs[8] ? BYTE_BIAS : ~BYTE_BIAS)
                                                      : bs[7:0];
          endcase
        end
      end
      default: illegal = 1'b1; // Unused opcode codes
    endcase
  end

  // Result register: one clock after acceptance
  always_comb begin
    rsp_d.valid   = req_valid;
    rsp_d.illegal = req_valid & illegal;
    rsp_d.data    = (req_valid && !illegal) ? res : '0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst)
      rsp_q <= '0;
    else
      rsp_q <= rsp_d;
  end

  assign rsp = rsp_q;

endmodule
`default_nettype wire

// File: dv/pmx_datapath_sva.sv
// Checker: port-level properties of the packed datapath
`timescale 1ns/100ps
`default_nettype none
module pmx_datapath_sva
  import pmx_pkg::*;
(
  input wire logic     mclk,
  input wire logic     sys_rst,
  input wire logic     req_valid,
  input wire pmx_req_t req,
  input wire pmx_rsp_t rsp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Every request answers exactly one clock later, idle cycles stay quiet
  AST_RSP_NEXT: assert property (req_valid |=> rsp.valid)
    else $error("no response one cycle after request");
  AST_NO_SPURIOUS: assert property (!req_valid |=> !rsp.valid)
    else $error("response without request");
  // Reset is not a disable here: the cleared output is the point
  AST_RESET_CLEAR: assert property (@(posedge mclk) disable iff (1'b0)
    sys_rst |=> rsp == '0)
    else $error("response not cleared by reset");
  AST_NARROW_UPPER: assert property (req_valid && !req.wide |=> rsp.data[127:64] == '0)
    else $error("narrow result upper half not zero");
  AST_ILLEGAL_ZERO: assert property (rsp.illegal |-> rsp.valid && rsp.data == '0)
    else $error("refused result carries data");
  AST_MAX_SW_LANE0: assert property (req_valid && req.op == max_signed_word_op |=>
    rsp.data[15:0] == (($signed($past(req.dst[15:0])) > $signed($past(req.src[15:0])))
    ? $past(req.dst[15:0]) : $past(req.src[15:0])))
    else $error("signed word max lane 0 wrong");
  AST_MIN_UB_LANE7: assert property (req_valid && req.op == min_unsigned_byte_op |=>
    rsp.data[63:56] == (($past(req.dst[63:56]) < $past(req.src[63:56]))
    ? $past(req.dst[63:56]) : $past(req.src[63:56])))
    else $error("unsigned byte min lane 7 wrong");
  AST_SAD_UPPER: assert property (req_valid && req.op == sum_abs_diff_byte_op |=>
    rsp.data[63:16] == '0 && rsp.data[127:80] == '0)
    else $error("sum of differences upper words not zero");
  AST_NARROW_DW_REFUSED: assert property (req_valid && !req.wide &&
    req.op inside {mul_low_signed_dword_op, mul_signed_dword_wide_op} |=> rsp.illegal)
    else $error("narrow signed dword multiply not refused");
endmodule
bind pmx_datapath pmx_datapath_sva u_sva (
  .mclk      (mclk),
  .sys_rst   (sys_rst),
  .req_valid (req_valid),
  .req       (req),
  .rsp       (rsp)
);
`default_nettype wire

// File: dv/pmx_issue_model.sv
// Issue-side model: presents requests as instruction issue would
`timescale 1ns/100ps
`default_nettype none
module pmx_issue_model
  import pmx_pkg::*;
(
  input  wire logic mclk,
  output var logic  req_valid,
  output var pmx_req_t req
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // Present one request; hold keeps valid up for back-to-back issue
  task automatic send(input pmx_op_t op, input logic wide, input logic mem,
                      input logic [127:0] a, input logic [127:0] b, input logic hold);
    req_valid = 1'b1;
    req = '{op: op, wide: wide, src_mem: mem, dst: a, src: b};
    @(posedge mclk);
    #1;
    if (!hold) begin
      // Released operands turn to garbage so stale values never pass
      req_valid = 1'b0;
      req.dst = ~req.dst;
      req.src = ~req.src;
    end
  endtask
endmodule
`default_nettype wire

// File: dv/pmx_datapath_test.sv
// Self-checking testbench of the packed datapath
`timescale 1ns/100ps
`default_nettype none
module pmx_datapath_test;
  import pmx_pkg::*;
  logic     mclk;
  logic     sys_rst;
  logic     req_valid;
  pmx_req_t req;
  pmx_rsp_t rsp;
  int       error_cnt;
  int       compares;
  logic [127:0] cur;

  pmx_issue_model u_iss (.mclk(mclk), .req_valid(req_valid), .req(req));
  pmx_datapath u_dut (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .rsp(rsp));

  // Clock, 25 ns period
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  task automatic check(input string what, input pmx_rsp_t got, input pmx_rsp_t exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [127:0] rep(input logic w, input logic [63:0] x);
    return w ? {x, x} : {64'h0, x};
  endfunction
  // One request, then compare the response it gives a clock later.
  // Valid stays up so the next call never re-raises it in the same step.
  task automatic run(input string what, input pmx_op_t op, input logic w, input logic [127:0] a,
                     input logic [127:0] b, input logic [127:0] exp, input logic ill);
    u_iss.send(op, w, w, a, b, 1'b1);
    check(what, rsp, '{1'b1, ill, exp});
    cur = exp;
  endtask

  task automatic t_minmax;
    logic [63:0] a, b, c, d;
    a = 64'h8000_7FFF_FFFF_0001; b = 64'h7FFF_8000_0001_FFFF;
    c = 64'hFF00_807F_0102_0304; d = 64'h00FF_7F80_0201_0403;
    for (int w = 0; w < 2; w++) begin
      run("max_sw", max_signed_word_op, w[0], {a, a}, {b, b}, rep(w[0], 64'h7FFF_7FFF_0001_0001), 0);
      run("min_sw", min_signed_word_op, w[0], {a, a}, {b, b}, rep(w[0], 64'h8000_8000_FFFF_FFFF), 0);
      run("max_ub", max_unsigned_byte_op, w[0], {c, c}, {d, d}, rep(w[0], 64'hFFFF_8080_0202_0404), 0);
      run("min_ub", min_unsigned_byte_op, w[0], {c, c}, {d, d}, rep(w[0], 64'h0000_7F7F_0101_0303), 0);
    end
  endtask
  // Wide-only element types; 0x80 patterns split signed from unsigned order
  task automatic t_wide_types;
    logic sgn;
    for (int i = 4; i < 12; i++) begin
      sgn = (i < 6) || (i == 8) || (i == 9);
      run("wide_mm", pmx_op_t'(i[4:0]), 1, {16{8'h80}}, {16{8'h7F}}, ((i % 2 == 0) == sgn) ? {16{8'h7F}} : {16{8'h80}}, 0);
      run("narrow_mm", pmx_op_t'(i[4:0]), 0, {16{8'h80}}, {16{8'h7F}}, '0, 1);
    end
  endtask
  task automatic t_mul;
    logic [63:0] a, b;
    logic [127:0] p, q;
    a = 64'hFFFF_8000_7FFF_1234; b = 64'h0002_8000_0003_0010;
    for (int w = 0; w < 2; w++) begin
      run("mulhu", mul_high_unsigned_word_op, w[0], {a, a}, {b, b}, rep(w[0], 64'h0001_4000_0001_0001), 0);
      run("mulhs", mul_high_signed_word_op, w[0], {a, a}, {b, b}, rep(w[0], 64'hFFFF_4000_0001_0001), 0);
      run("mullw", mul_low_word_op, w[0], {a, a}, {b, b}, rep(w[0], 64'hFFFE_0000_7FFD_2340), 0);
    end
    p = {32'h1234_5678, 32'h0000_0002, 32'h1234_5678, 32'hFFFF_FFFF};
    q = {32'h5555_5555, 32'h8000_0000, 32'h5555_5555, 32'hFFFF_FFFF};
    run("muludq_w", mul_unsigned_dword_wide_op, 1, p, q, {64'h1_0000_0000, 64'hFFFF_FFFE_0000_0001}, 0);
    run("muludq_n", mul_unsigned_dword_wide_op, 0, p, q, {64'h0, 64'hFFFF_FFFE_0000_0001}, 0);
    run("muldq_w", mul_signed_dword_wide_op, 1, p, q, {64'hFFFF_FFFF_0000_0000, 64'h1}, 0);
    run("muldq_n", mul_signed_dword_wide_op, 0, p, q, '0, 1);
    p = {32'h0000_0003, 32'h8000_0000, 32'h0001_0000, 32'hFFFF_FFFF};
    q = {32'hFFFF_FFFF, 32'h0000_0002, 32'h0001_0000, 32'h0000_0002};
    run("mulld", mul_low_signed_dword_op, 1, p, q, {32'hFFFF_FFFD, 64'h0, 32'hFFFF_FFFE}, 0);
  endtask
  task automatic t_sad;
    logic [127:0] a, b;
    a = {64'h0101_0101_0101_0101, 64'h00FF_1020_0000_0000};
    b = {64'h0, 64'hFF00_2010_0000_0000};
    run("sad_w", sum_abs_diff_byte_op, 1, a, b, {64'h8, 64'h21E}, 0);
    run("sad_n", sum_abs_diff_byte_op, 0, a, b, {64'h0, 64'h21E}, 0);
  endtask
  // Clip sequences chained through the expected value of each step
  task automatic t_clip;
    run("clip_min", min_signed_word_op, 0, 64'h8000_7FFF_0005_FFF0, {4{16'h0010}}, 64'h8000_0010_0005_FFF0, 0);
    run("clip_max", max_signed_word_op, 0, cur, {4{16'hFFF8}}, 64'hFFF8_0010_0005_FFF8, 0);
    run("uclip1", add_sat_unsigned_word_op, 0, 64'h0000_FFFF_0050_0020, {4{16'hFF9F}}, 64'hFF9F_FFFF_FFEF_FFBF, 0);
    run("uclip2", sub_sat_unsigned_word_op, 0, cur, {4{16'hFFCF}}, 64'h0000_0030_0020_0000, 0);
    run("uclip3", add_wrap_word_op, 0, cur, {4{16'h0030}}, 64'h0030_0060_0050_0030, 0);
    run("sclip0", add_wrap_word_op, 0, 64'h8000_7FFF_0005_FFF0, {4{WORD_BIAS}}, 64'h0000_FFFF_8005_7FF0, 0);
    run("sclip1", add_sat_unsigned_word_op, 0, cur, {4{16'h7FEF}}, 64'h7FEF_FFFF_FFF4_FFDF, 0);
    run("sclip2", sub_sat_unsigned_word_op, 0, cur, {4{16'hFFE7}}, 64'h0000_0018_000D_0000, 0);
    run("sclip3", add_wrap_word_op, 0, cur, {4{16'hFFF8}}, 64'hFFF8_0010_0005_FFF8, 0);
  endtask
  task automatic t_sat;
    run("adds_w", add_sat_signed_word_op, 0, 64'h7FFF_8000_0001_FFFF, 64'h0001_FFFF_0002_FFFF, 64'h7FFF_8000_0003_FFFE, 0);
    run("subs_w", sub_sat_signed_word_op, 0, 64'h7FFF_8000_0001_FFFF, 64'h0001_FFFF_0002_FFFF, 64'h7FFE_8001_FFFF_0000, 0);
    run("adds_b", add_sat_signed_byte_op, 0, {4{16'h7F80}}, {4{16'h0180}}, {4{16'h7F80}}, 0);
    run("subs_b", sub_sat_signed_byte_op, 0, {4{16'h7F80}}, {4{16'h0180}}, {4{16'h7E00}}, 0);
    run("addus_b", add_sat_unsigned_byte_op, 0, {4{16'h7F80}}, {4{16'h0180}}, {4{16'h80FF}}, 0);
    run("subus_b", sub_sat_unsigned_byte_op, 0, {4{16'h7F80}}, {4{16'h0180}}, {4{16'h7E00}}, 0);
    run("add_b", add_wrap_byte_op, 0, {4{16'h7F80}}, {4{16'h0180}}, {4{16'h8000}}, 0);
  endtask
  // Unused code, back-to-back issue and a reset with a request pending
  task automatic t_misc;
    run("bad_code", pmx_op_t'(5'h1D), 1, '1, '1, '0, 1);
    u_iss.send(max_signed_word_op, 0, 0, {4{16'hFFFF}}, {4{16'h0001}}, 1);
    check("b2b_max", rsp, '{1'b1, 1'b0, {4{16'h0001}}});
    run("b2b_min", min_signed_word_op, 0, {4{16'hFFFF}}, {4{16'h0001}}, {4{16'hFFFF}}, 0);
    sys_rst = 1'b1;
    u_iss.send(max_signed_word_op, 1, 0, '1, '0, 0);
    check("rst_drop", rsp, '0);
    sys_rst = 1'b0;
  endtask

  task automatic print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    error_cnt = 0;
    compares = 0;
    repeat (6) @(posedge mclk);
    #1 sys_rst = 1'b0;
    t_minmax;
    t_wide_types;
    t_mul;
    t_sad;
    t_clip;
    t_sat;
    t_misc;
    print_verdict;
  end
  // Watchdog, far beyond the about 63 cycles the run needs
  initial begin
    #100us;
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
